/* hdl/asc_pkg.sv */
// Constants, register map and carriers for the scan and pin configuration block.
// Assumes a 32-bit AHB-Lite register bus and a 10 MHz core clock.
package asc_pkg;

	localparam int ASC_NUM_INPUTS = 9;
	localparam int ASC_IDX_W = 4;
	localparam int ASC_REG_W = 16;
	localparam int ASC_DATA_W = 32;
	localparam int ASC_CH0_W = 5;

	// Byte addresses of the registers
	localparam logic [7:0] ASC_ADDR_SCAN = 8'h00;
	localparam logic [7:0] ASC_ADDR_PIN = 8'h04;
	localparam logic [7:0] ASC_ADDR_CTRL = 8'h08;
	localparam logic [7:0] ASC_ADDR_STAT = 8'h0c;

	// Reset values
	localparam logic [ASC_NUM_INPUTS-1:0] ASC_SCAN_RST = 9'h000;
	localparam logic [ASC_NUM_INPUTS-1:0] ASC_PIN_RST = 9'h000;

	// Control register fields
	localparam int ASC_CTRL_SCAN_EN = 0;
	localparam int ASC_CTRL_DISABLE = 1;
	localparam int ASC_CTRL_CH0_LSB = 8;

	// Status register fields
	localparam int ASC_STAT_IDX_LSB = 0;
	localparam int ASC_STAT_LOW_REF = 4;
	localparam int ASC_STAT_SCAN = 5;

	// AHB encodings
	localparam logic [1:0] ASC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] ASC_HSIZE_WORD = 3'h2;
	localparam logic ASC_HRESP_OKAY = 1'h0;

	typedef struct packed {
		logic [ASC_CH0_W-1:0] ch0_sel;
		logic converter_module_disable;
		logic scan_enable_ctrl;
	} asc_ctrl_s;

	typedef struct packed {
		logic [ASC_IDX_W-1:0] input_num;
		logic low_reference_voltage;
	} asc_sel_s;

	localparam asc_ctrl_s ASC_CTRL_RST = '{ch0_sel: 5'h00,
		converter_module_disable: 1'h0, scan_enable_ctrl: 1'h0};

endpackage

/* hdl/asc_scan_seq.sv */
// Scan sequencer: walks the selected inputs in ascending order.
// Assumes step_i is a one-cycle pulse on the core clock.
`timescale 1ns/100ps
module asc_scan_seq import asc_pkg::*; #(
	parameter int NUM_INPUTS = ASC_NUM_INPUTS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [NUM_INPUTS-1:0] scan_mask_i,
	input wire logic run_i,
	input wire logic step_i,
	output logic [ASC_IDX_W-1:0] cur_o,
	output logic any_o
);

	logic [ASC_IDX_W-1:0] cur;
	logic [ASC_IDX_W-1:0] next_cur;

	// First selected input after "from", wrapping; lowest offset wins
	function automatic int pick(input logic [NUM_INPUTS-1:0] m, input int from);
		int r;
		r = from;
		for (int k = NUM_INPUTS; k >= 1; k--) begin
			if (m[(from + k) % NUM_INPUTS])
				r = (from + k) % NUM_INPUTS;
		end
		return r;
	endfunction

	always_comb begin
		next_cur = cur;
		if (!run_i) begin
			// Idle: park on lowest selected so a scan starts there [R10]
			next_cur = ASC_IDX_W'(pick(scan_mask_i, NUM_INPUTS - 1));
		end else if (step_i) begin
			// One input per sample/convert sequence, ascending, wrapping [R10]
			next_cur = ASC_IDX_W'(pick(scan_mask_i, int'(cur)));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign cur_o = cur;
	assign any_o = |scan_mask_i;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_STEP_LANDS_SELECTED: assert property ( // [R10]
		run_i && step_i && |scan_mask_i |=> scan_mask_i[cur])
		else $error("Scan step landed on an unselected input");
	AST_STEP_ASCENDS: assert property ( // [R10]
		run_i && step_i && scan_mask_i[cur] && (cur < ASC_IDX_W'(NUM_INPUTS - 1))
		&& scan_mask_i[cur + 1'b1] && $stable(scan_mask_i)[*1]
		|=> cur == $past(cur) + 1'b1)
		else $error("Scan did not advance to the next higher input");

endmodule

/* hdl/asc_top.sv */
// Input scan selection and analog/digital pin configuration with AHB-Lite slave.
// Assumes one AHB-Lite master, word transfers, and a converter on the same clock.
// Notes on behaviour
// [R1]: scan bits include or skip each input
// [R2]: absent selected inputs convert low reference
// [R3]: scan bit x means analog input x
// [R4]: config one: digital, port read, mux grounded
// [R5]: config zero: analog, read off, sampled
// [R6]: absent-pin config bits stored, no effect
// [R7]: converter disabled forces all pins digital
// [R8]: config bit x controls analog input x
// [R9]: scan bits act only while scan enabled
// [R10]: ascending scan, one per sequence, wraps
// [R11]: registers reset zero, upper bits read zero
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module asc_top import asc_pkg::*; #(
	parameter int NUM_PRESENT = ASC_NUM_INPUTS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [ASC_DATA_W-1:0] hwdata_i,
	input wire logic hready_i,
	output logic [ASC_DATA_W-1:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic conv_seq_done_i,
	output logic [ASC_IDX_W-1:0] conv_input_o,
	output logic conv_low_ref_o,
	output logic [ASC_NUM_INPUTS-1:0] port_read_en_o,
	output logic [ASC_NUM_INPUTS-1:0] mux_ground_o
);

	if (NUM_PRESENT < 1 || NUM_PRESENT > ASC_NUM_INPUTS) begin : g_bad_present
		$error("NUM_PRESENT must lie between 1 and 9");
	end

	localparam logic [ASC_NUM_INPUTS-1:0] PRESENT_MASK =
		ASC_NUM_INPUTS'((1 << NUM_PRESENT) - 1);

	// Bus state
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [ASC_DATA_W-1:0] rdata;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [ASC_DATA_W-1:0] next_rdata;

	// Register state
	logic [ASC_NUM_INPUTS-1:0] scan_input_select_bits;
	logic [ASC_NUM_INPUTS-1:0] pin_digital_select_bits;
	asc_ctrl_s ctrl;
	logic [ASC_NUM_INPUTS-1:0] next_scan_sel;
	logic [ASC_NUM_INPUTS-1:0] next_pin_sel;
	asc_ctrl_s next_ctrl;

	// Output state
	asc_sel_s sel;
	asc_sel_s next_sel;
	logic [ASC_NUM_INPUTS-1:0] port_rd;
	logic [ASC_NUM_INPUTS-1:0] gnd_tie;
	logic [ASC_NUM_INPUTS-1:0] next_port_rd;
	logic [ASC_NUM_INPUTS-1:0] next_gnd_tie;

	logic [ASC_IDX_W-1:0] seq_cur;
	logic seq_any;
	logic scanning;
	logic addr_phase;

	// Word-aligned register read view; bits above a field read zero [R11]
	function automatic logic [ASC_DATA_W-1:0] read_reg(
		input logic [7:0] a,
		input logic [ASC_NUM_INPUTS-1:0] s,
		input logic [ASC_NUM_INPUTS-1:0] p,
		input asc_ctrl_s c,
		input asc_sel_s st,
		input logic run);
		logic [ASC_DATA_W-1:0] d;
		d = '0;
		case (a)
			ASC_ADDR_SCAN: d[ASC_NUM_INPUTS-1:0] = s;
			ASC_ADDR_PIN: d[ASC_NUM_INPUTS-1:0] = p;
			ASC_ADDR_CTRL: begin
				d[ASC_CTRL_SCAN_EN] = c.scan_enable_ctrl;
				d[ASC_CTRL_DISABLE] = c.converter_module_disable;
				d[ASC_CTRL_CH0_LSB +: ASC_CH0_W] = c.ch0_sel;
			end
			ASC_ADDR_STAT: begin
				d[ASC_STAT_IDX_LSB +: ASC_IDX_W] = st.input_num;
				d[ASC_STAT_LOW_REF] = st.low_reference_voltage;
				d[ASC_STAT_SCAN] = run;
			end
			default: d = '0;
		endcase
		return d;
	endfunction

	assign addr_phase = hsel_i && hready_i && htrans_i[1];
	assign scanning = ctrl.scan_enable_ctrl && !ctrl.converter_module_disable;

	// Bus pipeline: writes land in the data phase
	always_comb begin
		next_wr_pend = 1'b0;
		next_wr_addr = wr_addr;
		if (addr_phase) begin
			// Only whole-word writes are taken; others are ignored
			next_wr_pend = hwrite_i && (hsize_i == ASC_HSIZE_WORD);
			next_wr_addr = {haddr_i[7:2], 2'b00};
		end
	end

	// Register file
	always_comb begin
		next_scan_sel = scan_input_select_bits;
		next_pin_sel = pin_digital_select_bits;
		next_ctrl = ctrl;
		if (wr_pend) begin
			case (wr_addr)
				// All nine bits writable on any variant [R2] [R6]
				ASC_ADDR_SCAN: next_scan_sel = hwdata_i[ASC_NUM_INPUTS-1:0]; // [R1]
				ASC_ADDR_PIN: next_pin_sel = hwdata_i[ASC_NUM_INPUTS-1:0];
				ASC_ADDR_CTRL: begin
					next_ctrl.scan_enable_ctrl = hwdata_i[ASC_CTRL_SCAN_EN];
					next_ctrl.converter_module_disable = hwdata_i[ASC_CTRL_DISABLE];
					next_ctrl.ch0_sel = hwdata_i[ASC_CTRL_CH0_LSB +: ASC_CH0_W];
				end
				default: next_scan_sel = scan_input_select_bits;
			endcase
		end
	end

	// Read data from next values so a write just ahead is seen
	always_comb begin
		next_rdata = rdata;
		if (addr_phase && !hwrite_i)
			next_rdata = read_reg({haddr_i[7:2], 2'b00}, next_scan_sel, next_pin_sel,
				next_ctrl, sel, scanning);
	end

	asc_scan_seq #(
		.NUM_INPUTS(ASC_NUM_INPUTS)
	) u_seq (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.scan_mask_i(scan_input_select_bits), // [R3]
		.run_i(scanning && seq_any),
		.step_i(conv_seq_done_i),
		.cur_o(seq_cur),
		.any_o(seq_any)
	);

	// Converter input selection
	always_comb begin
		next_sel = sel;
		if (scanning && seq_any) begin
			next_sel.input_num = seq_cur; // [R9]
			// Selected but not bonded out: convert low reference [R2]
			next_sel.low_reference_voltage = !PRESENT_MASK[seq_cur];
		end else begin
			// Scan off or no input selected: channel-0 positive select applies [R9]
			next_sel.input_num = ctrl.ch0_sel[ASC_IDX_W-1:0];
			next_sel.low_reference_voltage =
				(ctrl.ch0_sel >= ASC_CH0_W'(NUM_PRESENT));
		end
	end

	// Pin configuration
	always_comb begin
		next_port_rd = '0;
		next_gnd_tie = '1;
		for (int i = 0; i < ASC_NUM_INPUTS; i++) begin
			if (!PRESENT_MASK[i]) begin
				// No pin behind this bit, so the bit is inert [R6]
				next_port_rd[i] = 1'b0;
				next_gnd_tie[i] = 1'b1;
			end else if (ctrl.converter_module_disable) begin
				next_port_rd[i] = 1'b1; // [R7]
				next_gnd_tie[i] = 1'b1;
			end else begin
				// Bit i drives pin i [R8]; one digital [R4], zero analog [R5]
				next_port_rd[i] = pin_digital_select_bits[i];
				next_gnd_tie[i] = pin_digital_select_bits[i];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			rdata <= '0;
			scan_input_select_bits <= ASC_SCAN_RST; // [R11]
			pin_digital_select_bits <= ASC_PIN_RST; // [R11]
			ctrl <= ASC_CTRL_RST;
			sel <= '0;
			port_rd <= '0;
			gnd_tie <= '1;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			rdata <= next_rdata;
			scan_input_select_bits <= next_scan_sel;
			pin_digital_select_bits <= next_pin_sel;
			ctrl <= next_ctrl;
			sel <= next_sel;
			port_rd <= next_port_rd;
			gnd_tie <= next_gnd_tie;
		end
	end

	// Zero wait states; always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = ASC_HRESP_OKAY;
	assign hrdata_o = rdata;
	assign conv_input_o = sel.input_num;
	assign conv_low_ref_o = sel.low_reference_voltage;
	assign port_read_en_o = port_rd;
	assign mux_ground_o = gnd_tie;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_SCAN_OFF_CH0: assert property ( // [R9]
		!scanning ##1 !scanning && $stable(ctrl.ch0_sel)
		|-> conv_input_o == ctrl.ch0_sel[ASC_IDX_W-1:0])
		else $error("Channel-0 select not applied with scan off");
	AST_SCAN_PICKS_SELECTED: assert property ( // [R1]
		scanning && seq_any |=> scan_input_select_bits == $past(scan_input_select_bits)
		|-> $past(scan_input_select_bits[seq_cur]))
		else $error("Scan visited an unselected input");
	AST_ABSENT_LOW_REF: assert property ( // [R2]
		scanning && seq_any && seq_cur >= ASC_IDX_W'(NUM_PRESENT) |=> conv_low_ref_o)
		else $error("Absent input not converted as low reference");
	AST_SCAN_OFF_LOW_REF: assert property ( // [R9]
		!(scanning && seq_any) |=>
		conv_low_ref_o == ($past(ctrl.ch0_sel) >= ASC_CH0_W'(NUM_PRESENT)))
		else $error("Channel-0 low reference flag wrong with scan off");
	AST_SCAN_IN_RANGE: assert property ( // [R3]
		scanning && seq_any |=> conv_input_o < ASC_IDX_W'(ASC_NUM_INPUTS))
		else $error("Scan selected an input beyond the last");

	// Pin side: each present pin follows its bit unless the converter is off
	AST_DIGITAL_PIN: assert property ( // [R4]
		!ctrl.converter_module_disable && pin_digital_select_bits[0] && PRESENT_MASK[0]
		|=> port_read_en_o[0] && mux_ground_o[0])
		else $error("Digital pin not configured");
	AST_ANALOG_PIN: assert property ( // [R5]
		!ctrl.converter_module_disable && !pin_digital_select_bits[0]
		##1 !ctrl.converter_module_disable && !pin_digital_select_bits[0]
		|-> !port_read_en_o[0] && !mux_ground_o[0])
		else $error("Analog pin not configured");
	AST_DISABLED_DIGITAL: assert property ( // [R7]
		ctrl.converter_module_disable |=> (port_read_en_o & PRESENT_MASK) == PRESENT_MASK)
		else $error("Disabled converter left a pin analog");
	AST_DISABLED_GROUNDED: assert property ( // [R7]
		ctrl.converter_module_disable |=> (mux_ground_o & PRESENT_MASK) == PRESENT_MASK)
		else $error("Disabled converter left a mux input on a pin");
	AST_PIN_BIT_MAP: assert property ( // [R8]
		!ctrl.converter_module_disable |=>
		(port_read_en_o & PRESENT_MASK) == ($past(pin_digital_select_bits) & PRESENT_MASK))
		else $error("Pin configuration bit mapped to wrong pin");
	AST_PIN_GROUND_MAP: assert property ( // [R4]
		!ctrl.converter_module_disable |=>
		(mux_ground_o & PRESENT_MASK) == ($past(pin_digital_select_bits) & PRESENT_MASK))
		else $error("Mux grounding does not follow the pin bit");
	AST_ABSENT_INERT: assert property ( // [R6]
		1'b1 |-> (port_read_en_o & ~PRESENT_MASK) == '0)
		else $error("Absent pin enabled its port read");
	AST_ABSENT_GROUNDED: assert property ( // [R6]
		1'b1 |-> (mux_ground_o & ~PRESENT_MASK) == ~PRESENT_MASK)
		else $error("Absent pin mux input not grounded");

	// Bus side: storage, refusal and read view
	AST_WRITE_STORES: assert property ( // [R1]
		addr_phase && hwrite_i && hsize_i == ASC_HSIZE_WORD
		&& {haddr_i[7:2], 2'b00} == ASC_ADDR_SCAN
		|=> ##1 scan_input_select_bits == $past(hwdata_i[ASC_NUM_INPUTS-1:0]))
		else $error("Scan select write not stored");
	AST_PIN_WRITE_STORES: assert property ( // [R8]
		addr_phase && hwrite_i && hsize_i == ASC_HSIZE_WORD
		&& {haddr_i[7:2], 2'b00} == ASC_ADDR_PIN
		|=> ##1 pin_digital_select_bits == $past(hwdata_i[ASC_NUM_INPUTS-1:0]))
		else $error("Pin configuration write not stored");
	AST_NARROW_REFUSED: assert property ( // [R1]
		addr_phase && hwrite_i && hsize_i != ASC_HSIZE_WORD |=> !wr_pend)
		else $error("Narrow write was taken");
	AST_UPPER_ZERO: assert property ( // [R11]
		addr_phase && !hwrite_i && {haddr_i[7:2], 2'b00} == ASC_ADDR_PIN
		|=> hrdata_o[ASC_DATA_W-1:ASC_NUM_INPUTS] == '0)
		else $error("Unimplemented bits read nonzero");
	AST_SCAN_UPPER_ZERO: assert property ( // [R11]
		addr_phase && !hwrite_i && {haddr_i[7:2], 2'b00} == ASC_ADDR_SCAN
		|=> hrdata_o[ASC_DATA_W-1:ASC_NUM_INPUTS] == '0)
		else $error("Unimplemented scan bits read nonzero");
	AST_BUS_OKAY: assert property (
		1'b1 |-> hreadyout_o && hresp_o == ASC_HRESP_OKAY)
		else $error("Bus answer not zero-wait OKAY");

	COV_SCAN_STEP: cover property (scanning && seq_any && conv_seq_done_i);
	COV_DISABLED: cover property (ctrl.converter_module_disable && |pin_digital_select_bits);
	COV_LOW_REF: cover property (conv_low_ref_o && scanning);
	COV_NARROW_WRITE: cover property (addr_phase && hwrite_i && hsize_i != ASC_HSIZE_WORD);
	COV_ANALOG_PIN: cover property (!ctrl.converter_module_disable && !mux_ground_o[0]);

endmodule

/* verification/adc_scan_and_pin_config_tb.sv */
// Self-checking bench for the scan and pin configuration block.
// Assumes a single AHB-Lite master with zero-wait answers and six bonded inputs.
`timescale 1ns/100ps
module adc_scan_and_pin_config_tb;
	import asc_pkg::*;
	localparam int PRESENT = 6;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = ASC_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic seq_done;
	logic [ASC_IDX_W-1:0] conv_input;
	logic conv_low_ref;
	logic [8:0] read_en;
	logic [8:0] gnd_tie;
	logic [31:0] rd;
	int error_cnt = 0;
	int checks = 0;

	always #50 core_clk_i = ~core_clk_i;

	asc_top #(.NUM_PRESENT(PRESENT)) i_asc_top (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.conv_seq_done_i(seq_done), .conv_input_o(conv_input), .conv_low_ref_o(conv_low_ref),
		.port_read_en_o(read_en), .mux_ground_o(gnd_tie));

	asc_conv_model i_asc_conv_model (
		.core_clk_i(core_clk_i), .go_i(go), .slow_i(slow), .done_o(seq_done));

	task automatic final_report();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single transfer; address phase held until hready is seen high
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk_i);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= ASC_HTRANS_NONSEQ;
		hwrite <= wr;
		do begin @(posedge core_clk_i); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge core_clk_i); n++; end while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, {31'h0, ASC_HRESP_OKAY});
		if (n >= 100) chk("bus answer", 32'h0, 32'h1);
	endtask

	// Register update lands one edge, outputs one edge later
	task automatic settle();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask

	task automatic pins(input logic [8:0] en, input logic [8:0] gnd);
		chk("port_read_en", {23'h0, read_en}, {23'h0, en});
		chk("mux_ground", {23'h0, gnd_tie}, {23'h0, gnd});
	endtask

	task automatic sel(input logic [3:0] idx, input logic vr);
		chk("conv_input", {28'h0, conv_input}, {28'h0, idx});
		chk("conv_low_ref", {31'h0, conv_low_ref}, {31'h0, vr});
	endtask

	task automatic step(input logic s, input logic [3:0] idx, input logic vr);
		@(posedge core_clk_i);
		slow <= s;
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		#1;
		sel(idx, vr);
	endtask

	task automatic test_reset();
		ahb(1'b0, ASC_ADDR_SCAN, 32'h0);
		chk("scan reset", rd, 32'h0);
		ahb(1'b0, ASC_ADDR_PIN, 32'h0);
		chk("pin reset", rd, 32'h0);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		settle();
		pins(9'h000, 9'h1c0);
	endtask

	task automatic test_pins();
		ahb(1'b1, ASC_ADDR_PIN, 32'hffff_ffff);
		ahb(1'b0, ASC_ADDR_PIN, 32'h0);
		chk("pin readback", rd, 32'h0000_01ff);
		settle();
		pins(9'h03f, 9'h1ff);
		ahb(1'b1, ASC_ADDR_PIN, 32'h0000_0005);
		settle();
		pins(9'h005, 9'h1c5);
		ahb(1'b1, ASC_ADDR_PIN, 32'h0);
		ahb(1'b1, ASC_ADDR_CTRL, 32'h0000_0002);
		settle();
		pins(9'h03f, 9'h1ff);
		ahb(1'b1, ASC_ADDR_CTRL, 32'h0);
		settle();
		pins(9'h000, 9'h1c0);
	endtask

	task automatic test_scan();
		ahb(1'b1, ASC_ADDR_SCAN, 32'hffff_ffff);
		ahb(1'b0, ASC_ADDR_SCAN, 32'h0);
		chk("scan readback", rd, 32'h0000_01ff);
		ahb(1'b1, ASC_ADDR_SCAN, 32'h0000_010a);
		ahb(1'b1, ASC_ADDR_CTRL, 32'h0000_0300);
		settle();
		sel(4'h3, 1'b0);
		ahb(1'b1, ASC_ADDR_CTRL, 32'h0000_0700);
		settle();
		sel(4'h7, 1'b1);
		ahb(1'b1, ASC_ADDR_CTRL, 32'h0000_0001);
		settle();
		sel(4'h1, 1'b0);
		step(1'b0, 4'h3, 1'b0);
		step(1'b1, 4'h8, 1'b1);
		step(1'b0, 4'h1, 1'b0);
		hsize <= 3'h0;
		ahb(1'b1, ASC_ADDR_SCAN, 32'h0000_01ff);
		hsize <= ASC_HSIZE_WORD;
		ahb(1'b0, ASC_ADDR_SCAN, 32'h0);
		chk("narrow write refused", rd, 32'h0000_010a);
		ahb(1'b0, ASC_ADDR_STAT, 32'h0);
		chk("status", rd, 32'h0000_0021);
	endtask

	// Reset in mid-run must bring the scan and control registers and every output back to idle
	task automatic test_rerun();
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		ahb(1'b0, ASC_ADDR_SCAN, 32'h0);
		chk("scan after reset", rd, 32'h0);
		ahb(1'b0, ASC_ADDR_CTRL, 32'h0);
		chk("ctrl after reset", rd, 32'h0);
		settle();
		pins(9'h000, 9'h1c0);
		sel(4'h0, 1'b0);
	endtask

	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		test_reset();
		test_pins();
		test_scan();
		test_rerun();
		final_report();
	end

	// Whole run is under two hundred cycles; this leaves wide margin
	initial begin
		#(100 * 5000);
		error_cnt++;
		final_report();
	end
endmodule

/* verification/asc_conv_model.sv */
// Behavioural converter partner: ends one sample/convert sequence per request.
// Assumes go_i is a one-cycle pulse driven on the core clock edge.
`timescale 1ns/100ps
module asc_conv_model (
	input wire logic core_clk_i,
	input wire logic go_i,
	input wire logic slow_i,
	output logic done_o
);
	initial done_o = 1'b0;
	// Slow mode stretches the conversion so the sequencer sees a late pulse
	always @(posedge core_clk_i) begin
		if (go_i) begin
			repeat (slow_i ? 5 : 1) @(posedge core_clk_i);
			done_o <= 1'b1;
			@(posedge core_clk_i);
			done_o <= 1'b0;
		end
	end
endmodule
